// >>> logic/cog_defs.svh
/*
 * Constants of the clock output stage: serial address map, byte indices,
 * field positions, reset values and divider codes.
 * Assumes inclusion by the design modules and the test host by bare name.
 */
`ifndef COG_DEFS_SVH
`define COG_DEFS_SVH

`define COG_DEV_ADDR 7'h69
`define COG_NUM_BYTES 42
`define COG_BANK_FIRST 8'h08
`define COG_BANK_LAST 8'h19
`define COG_TABLE_FIRST 8'h40
`define COG_TABLE_LAST 8'h57
`define COG_TABLE_BASE 8'h12

`define COG_IDX_DIV_A0 6'h00
`define COG_IDX_DIV_A1 6'h01
`define COG_IDX_DIV_B0 6'h02
`define COG_IDX_DIV_B1 6'h03
`define COG_IDX_DIV_C 6'h04
`define COG_IDX_DIV_D 6'h05
`define COG_IDX_FS_HI 6'h06
`define COG_IDX_MISC 6'h07
`define COG_IDX_DRIVE 6'h08
`define COG_IDX_PLL2 6'h09
`define COG_IDX_PLL3 6'h0c
`define COG_IDX_SUSP_OUT 6'h10
`define COG_IDX_SUSP_PLL 6'h11
`define COG_IDX_TABLE 6'h12

`define COG_FS_LO_BIT 7
`define COG_MISC_PDN_BIT 3
`define COG_MISC_XBUF_BIT 2
`define COG_PLL_EN_BIT 6
`define COG_PLL_PO_BIT 2
`define COG_DIVIDER_BANK_SELECT_BIT 7
`define COG_SUSP_MODE_BIT 3

`define COG_MISC_RST 8'h54
`define COG_DRIVE_RST 8'h55
`define COG_BYTE_RST 8'h00

`define COG_FS_REF 3'h0
`define COG_FS_RSVD 3'h1
`define COG_EDIV_OFF 2'h0
`define COG_EDIV_BY4 2'h1
`define COG_EDIV_BY2 2'h2
`define COG_P_OFFSET 12'h003
`define COG_Q_OFFSET 9'h002
`endif

// >>> logic/cog_pkg.sv
/*
 * Types shared by the clock output stage modules.
 * Assumes cog_defs.svh holds every number.
 */
package cog_pkg;
    typedef enum logic [3:0] {
        COG_SL_IDLE = 4'h0,
        COG_SL_DEV = 4'h1,
        COG_SL_DEV_ACK = 4'h2,
        COG_SL_PTR = 4'h3,
        COG_SL_PTR_ACK = 4'h4,
        COG_SL_WR = 4'h5,
        COG_SL_WR_ACK = 4'h6,
        COG_SL_RD = 4'h7,
        COG_SL_RD_ACK = 4'h8
    } cog_sl_state_t;

    // Half-period ticks of each source: one pulse per source edge
    typedef struct packed {
        logic ref_half;
        logic [2:0] pll_half;
    } cog_src_t;

    typedef struct packed {
        logic en;
        logic [2:0] lf;
        logic [11:0] pt;
        logic [8:0] qt;
    } cog_pll_cfg_t;

    typedef struct packed {
        logic out;
        logic oe;
        logic [1:0] duty;
        logic [1:0] drive;
    } cog_pad_t;
endpackage : cog_pkg

// >>> logic/cog_regfile.sv
/*
 * Configuration byte store of the clock output stage, with a registered
 * serial read port and every byte also visible in parallel.
 * Assumes one writer at a time and indices already range-checked.
 */
`timescale 1ns/10ps
`include "cog_defs.svh"
module cog_regfile
    import cog_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_we,
    input wire logic [5:0] i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic [5:0] i_raddr,
    output logic [7:0] o_rdata,
    output logic [`COG_NUM_BYTES*8-1:0] o_bytes
);
    logic [7:0] mem_reg [0:`COG_NUM_BYTES-1];

    genvar g;
    generate
        for (g = 0; g < `COG_NUM_BYTES; g++) begin : g_byte
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    mem_reg[g] <= (6'(g) == `COG_IDX_MISC) ? `COG_MISC_RST :
                                  (6'(g) == `COG_IDX_DRIVE) ? `COG_DRIVE_RST : `COG_BYTE_RST;
                end else if (i_we && i_waddr == 6'(g)) begin
                    mem_reg[g] <= i_wdata;
                end
            end
            assign o_bytes[g*8 +: 8] = mem_reg[g];
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_raddr < 6'(`COG_NUM_BYTES)) begin
            o_rdata <= mem_reg[i_raddr];
        end else begin
            o_rdata <= 8'h00;
        end
    end
endmodule : cog_regfile

// >>> logic/cog_top.sv
/*
 * Clock output stage: two-wire configuration slave, cross point, post
 * dividers A-E, buffered reference, shutdown/enable and suspend control,
 * PLL setting outputs.
 * Assumes source ticks come from logic on i_clk; pins are asynchronous.
 */
`timescale 1ns/10ps
`include "cog_defs.svh"
module cog_top
    import cog_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire cog_src_t i_src,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_shutdown_oe_pin,
    input wire logic i_freq_select_or_sleep_pin,
    output cog_pad_t [5:0] o_pad,
    output cog_pll_cfg_t [2:0] o_pll_cfg,
    output logic o_osc_enable
);
    localparam int NB = `COG_NUM_BYTES;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    function automatic logic [6:0] cog_map(input logic [7:0] a);
        if (a >= `COG_BANK_FIRST && a <= `COG_BANK_LAST) begin
            return {1'b1, 6'(a - `COG_BANK_FIRST)};
        end else if (a >= `COG_TABLE_FIRST && a <= `COG_TABLE_LAST) begin
            return {1'b1, 6'(a - `COG_TABLE_FIRST + `COG_TABLE_BASE)};
        end
        return 7'h00;
    endfunction : cog_map

    function automatic logic [7:0] cog_byte(input logic [NB*8-1:0] f, input logic [5:0] i);
        return f[{i, 3'h0} +: 8];
    endfunction : cog_byte

    function automatic cog_pll_cfg_t cog_pll(input logic [7:0] q, input logic [7:0] p,
                                             input logic [7:0] c, input logic run);
        cog_pll_cfg_t r;
        r.en = run;
        r.lf = c[5:3];
        r.pt = 12'({c[1:0], p} + `COG_P_OFFSET) * 12'h002 + 12'(c[`COG_PLL_PO_BIT]);
        r.qt = 9'(q) + `COG_Q_OFFSET;
        return r;
    endfunction : cog_pll

    // Pin synchronisers
    logic [1:0] scl_pipe_reg, sda_pipe_reg, pin_pipe_reg, sel_pipe_reg;
    logic scl_prev_reg, sda_prev_reg;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            scl_pipe_reg <= 2'h3;
            sda_pipe_reg <= 2'h3;
            pin_pipe_reg <= 2'h3;
            sel_pipe_reg <= 2'h3;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_pipe_reg <= {scl_pipe_reg[0], i_scl};
            sda_pipe_reg <= {sda_pipe_reg[0], i_sda};
            pin_pipe_reg <= {pin_pipe_reg[0], i_shutdown_oe_pin};
            sel_pipe_reg <= {sel_pipe_reg[0], i_freq_select_or_sleep_pin};
            scl_prev_reg <= scl_pipe_reg[1];
            sda_prev_reg <= sda_pipe_reg[1];
        end
    end
    logic scl_s, sda_s, pin_s, sel_s;
    assign scl_s = scl_pipe_reg[1];
    assign sda_s = sda_pipe_reg[1];
    assign pin_s = pin_pipe_reg[1];
    assign sel_s = sel_pipe_reg[1];

    // Synchronised serial pins caught once, at the first cycle after reset release, while they still hold the reset value 1
    logic strap_done_reg;
    logic [1:0] strap_reg;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            strap_done_reg <= 1'b0;
            strap_reg <= 2'h0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            strap_reg <= {scl_s, sda_s};
        end
    end

    // Two-wire slave; runs regardless of shutdown
    cog_sl_state_t sl_state_reg;
    logic [7:0] shift_reg, ptr_reg, tx_reg;
    logic [3:0] bit_cnt_reg;
    logic rw_reg, mem_we;
    logic [7:0] rdata;
    logic [NB*8-1:0] bytes;
    logic [6:0] ptr_map;
    logic start_cond, stop_cond, scl_rise, scl_fall;
    assign start_cond = scl_s && sda_prev_reg && !sda_s;
    assign stop_cond = scl_s && !sda_prev_reg && sda_s;
    assign scl_rise = scl_s && !scl_prev_reg;
    assign scl_fall = !scl_s && scl_prev_reg;
    assign ptr_map = cog_map(ptr_reg);
    // Commit lands with the acknowledge of each data byte to a mapped address
    assign mem_we = scl_fall && sl_state_reg == COG_SL_WR && bit_cnt_reg == 4'h8 && ptr_map[6];
    assign o_sda_out = 1'b0;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sl_state_reg <= COG_SL_IDLE;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            tx_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            rw_reg <= 1'b0;
            o_sda_oe <= 1'b0;
        end else if (start_cond) begin
            sl_state_reg <= COG_SL_DEV;
            bit_cnt_reg <= 4'h0;
            o_sda_oe <= 1'b0;
        end else if (stop_cond) begin
            sl_state_reg <= COG_SL_IDLE;
            o_sda_oe <= 1'b0;
        end else if (scl_rise) begin
            if (sl_state_reg inside {COG_SL_DEV, COG_SL_PTR, COG_SL_WR}) begin
                shift_reg <= {shift_reg[6:0], sda_s};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (sl_state_reg == COG_SL_RD_ACK) begin
                rw_reg <= !sda_s;
            end
        end else if (scl_fall) begin
            unique case (sl_state_reg)
                COG_SL_IDLE: begin
                    o_sda_oe <= 1'b0;
                end
                COG_SL_DEV: begin
                    if (bit_cnt_reg == 4'h8) begin
                        if (shift_reg[7:1] == `COG_DEV_ADDR) begin
                            rw_reg <= shift_reg[0];
                            o_sda_oe <= 1'b1;
                            sl_state_reg <= COG_SL_DEV_ACK;
                        end else begin
                            sl_state_reg <= COG_SL_IDLE;
                        end
                    end
                end
                COG_SL_DEV_ACK, COG_SL_RD_ACK: begin
                    bit_cnt_reg <= 4'h0;
                    if (!rw_reg) begin
                        o_sda_oe <= 1'b0;
                        sl_state_reg <= (sl_state_reg == COG_SL_DEV_ACK) ? COG_SL_PTR : COG_SL_IDLE;
                    end else begin
                        tx_reg <= ptr_map[6] ? {rdata[6:0], 1'b0} : 8'h00;
                        o_sda_oe <= ptr_map[6] ? !rdata[7] : 1'b1;
                        bit_cnt_reg <= 4'h1;
                        sl_state_reg <= COG_SL_RD;
                    end
                end
                COG_SL_PTR: begin
                    if (bit_cnt_reg == 4'h8) begin
                        ptr_reg <= shift_reg;
                        o_sda_oe <= 1'b1;
                        sl_state_reg <= COG_SL_PTR_ACK;
                    end
                end
                COG_SL_WR: begin
                    if (bit_cnt_reg == 4'h8) begin
                        o_sda_oe <= 1'b1;
                        sl_state_reg <= COG_SL_WR_ACK;
                    end
                end
                COG_SL_PTR_ACK, COG_SL_WR_ACK: begin
                    if (sl_state_reg == COG_SL_WR_ACK) begin
                        ptr_reg <= ptr_reg + 8'h01;
                    end
                    o_sda_oe <= 1'b0;
                    bit_cnt_reg <= 4'h0;
                    sl_state_reg <= COG_SL_WR;
                end
                COG_SL_RD: begin
                    if (bit_cnt_reg == 4'h8) begin
                        // Step early so the next byte is settled by the ack edge
                        ptr_reg <= ptr_reg + 8'h01;
                        o_sda_oe <= 1'b0;
                        sl_state_reg <= COG_SL_RD_ACK;
                    end else begin
                        o_sda_oe <= !tx_reg[7];
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                end
            endcase
        end
    end

    cog_regfile u_regfile (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_we(mem_we),
        .i_waddr(ptr_map[5:0]),
        .i_wdata(shift_reg),
        .i_raddr(ptr_map[5:0]),
        .o_rdata(rdata),
        .o_bytes(bytes)
    );

    // Power and suspend control
    logic [7:0] misc, drive, fs_hi, susp_out, susp_pll;
    logic pdn_en, tristate, halt, susp_active;
    logic [5:0] out_susp;
    logic [2:0] pll_susp, pll_run;
    assign misc = cog_byte(bytes, `COG_IDX_MISC);
    assign drive = cog_byte(bytes, `COG_IDX_DRIVE);
    assign fs_hi = cog_byte(bytes, `COG_IDX_FS_HI);
    assign susp_out = cog_byte(bytes, `COG_IDX_SUSP_OUT);
    assign susp_pll = cog_byte(bytes, `COG_IDX_SUSP_PLL);
    assign pdn_en = misc[`COG_MISC_PDN_BIT];
    assign tristate = !pin_s;
    assign halt = pdn_en && !pin_s;
    assign susp_active = susp_pll[`COG_SUSP_MODE_BIT] && !sel_s;
    assign out_susp = susp_out[5:0] & {6{susp_active}};
    assign pll_susp = susp_pll[2:0] & {3{susp_active}};

    // First PLL row: select pin (unless used as suspend) over start-up straps
    logic [2:0] row;
    logic [5:0] row_idx;
    logic [7:0] row_ctl;
    assign row = {susp_pll[`COG_SUSP_MODE_BIT] ? 1'b0 : sel_s, strap_reg};
    assign row_idx = `COG_IDX_TABLE + 6'(row) * 6'h03;
    assign row_ctl = cog_byte(bytes, row_idx + 6'h02);

    logic [7:0] pll_ctl [0:2];
    assign pll_ctl[0] = row_ctl;
    assign pll_ctl[1] = cog_byte(bytes, `COG_IDX_PLL2 + 6'h02);
    assign pll_ctl[2] = cog_byte(bytes, `COG_IDX_PLL3 + 6'h02);

    genvar k;
    generate
        for (k = 0; k < 3; k++) begin : g_pll
            assign pll_run[k] = pll_ctl[k][`COG_PLL_EN_BIT] && !halt && !pll_susp[k];
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_pll_cfg <= '0;
            o_osc_enable <= 1'b0;
        end else begin
            o_pll_cfg[0] <= cog_pll(cog_byte(bytes, row_idx), cog_byte(bytes, row_idx + 6'h01),
                                    row_ctl, pll_run[0]);
            o_pll_cfg[1] <= cog_pll(cog_byte(bytes, `COG_IDX_PLL2), cog_byte(bytes, `COG_IDX_PLL2 + 6'h01),
                                    pll_ctl[1], pll_run[1]);
            o_pll_cfg[2] <= cog_pll(cog_byte(bytes, `COG_IDX_PLL3), cog_byte(bytes, `COG_IDX_PLL3 + 6'h01),
                                    pll_ctl[2], pll_run[2]);
            o_osc_enable <= !halt;
        end
    end

    // Main outputs A-D: cross point and post dividers
    logic [5:0] level, active;
    logic [1:0] bank_reg;
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_main
            logic [2:0] fs;
            logic [6:0] div;
            logic [6:0] cnt_reg;
            logic level_reg, tick, src_ok, wrap;
            logic [1:0] pll_sel;
            logic [7:0] fs_byte, div_byte;
            assign fs_byte = cog_byte(bytes, (i < 2) ? 6'(2*i) : 6'(i+2));
            assign fs = {fs_hi[2*i+1 -: 2], fs_byte[`COG_FS_LO_BIT]};
            if (i < 2) begin : g_bank
                assign div_byte = cog_byte(bytes, 6'(2*i) + {5'h00, bank_reg[i]});
            end else begin : g_single
                assign div_byte = cog_byte(bytes, 6'(i+2));
            end
            assign div = div_byte[6:0];
            assign pll_sel = 2'(fs[2:1] - 2'h1);
            // Reserved code has no source and stays idle
            assign src_ok = (fs == `COG_FS_REF) || (fs != `COG_FS_RSVD && pll_run[pll_sel]);
            assign tick = (fs == `COG_FS_REF) ? i_src.ref_half : i_src.pll_half[pll_sel];
            assign active[i] = div != 7'h00 && src_ok && !halt && !out_susp[i];
            assign wrap = 8'(cnt_reg) + 8'h01 >= 8'(div);
            assign level[i] = level_reg;
            // Toggle every div half-periods: divide by div, 50% duty even for odd values
            always_ff @(posedge i_clk) begin
                if (i_reset || !active[i]) begin
                    cnt_reg <= 7'h00;
                    level_reg <= fs[0];
                end else if (tick) begin
                    if (wrap) begin
                        cnt_reg <= 7'h00;
                        level_reg <= !level_reg;
                    end else begin
                        cnt_reg <= cnt_reg + 7'h01;
                    end
                end
            end
            if (i < 2) begin : g_swap
                // Bank follows the select while idle, else only at the output edge back to the idle level fs[0]
                always_ff @(posedge i_clk) begin
                    if (i_reset) begin
                        bank_reg[i] <= 1'b0;
                    end else if (!active[i] || (tick && wrap && level_reg != fs[0])) begin
                        bank_reg[i] <= row_ctl[`COG_DIVIDER_BANK_SELECT_BIT];
                    end
                end
            end
        end
    endgenerate

    // Output E from first PLL 0 degree
    logic [1:0] ediv;
    logic [2:0] e_n, e_cnt_reg;
    logic e_level_reg;
    assign ediv = misc[1:0];
    assign e_n = (ediv == `COG_EDIV_BY4) ? 3'h4 : (ediv == `COG_EDIV_BY2) ? 3'h2 : 3'h3;
    assign active[4] = ediv != `COG_EDIV_OFF && pll_run[0] && !out_susp[4];
    assign level[4] = e_level_reg;
    always_ff @(posedge i_clk) begin
        if (i_reset || !active[4]) begin
            e_cnt_reg <= 3'h0;
            e_level_reg <= 1'b0;
        end else if (i_src.pll_half[0]) begin
            if (e_cnt_reg + 3'h1 >= e_n) begin
                e_cnt_reg <= 3'h0;
                e_level_reg <= !e_level_reg;
            end else begin
                e_cnt_reg <= e_cnt_reg + 3'h1;
            end
        end
    end

    // Buffered reference
    logic x_level_reg;
    assign active[5] = misc[`COG_MISC_XBUF_BIT] && !halt && !out_susp[5];
    assign level[5] = x_level_reg;
    always_ff @(posedge i_clk) begin
        if (i_reset || halt) begin
            x_level_reg <= 1'b0;
        end else if (i_src.ref_half) begin
            x_level_reg <= !x_level_reg;
        end
    end

    // Pads: A, B, C, D, E, buffered reference
    logic [1:0] duty_f [0:5];
    logic [1:0] drive_f [0:5];
    assign duty_f[0] = misc[5:4];
    assign duty_f[1] = misc[5:4];
    assign duty_f[2] = misc[7:6];
    assign duty_f[3] = misc[5:4];
    assign duty_f[4] = misc[5:4];
    assign duty_f[5] = misc[7:6];
    assign drive_f[0] = drive[1:0];
    assign drive_f[1] = drive[1:0];
    assign drive_f[2] = drive[3:2];
    assign drive_f[3] = drive[5:4];
    assign drive_f[4] = drive[5:4];
    assign drive_f[5] = drive[7:6];
    genvar j;
    generate
        for (j = 0; j < 6; j++) begin : g_pad
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    o_pad[j] <= '0;
                end else begin
                    o_pad[j].out <= level[j];
                    o_pad[j].oe <= active[j] && !tristate;
                    o_pad[j].duty <= duty_f[j];
                    o_pad[j].drive <= drive_f[j];
                end
            end
        end
    endgenerate

    pin_tristate_a: assert property (!pin_s |=> o_pad[0].oe == 1'b0 && o_pad[3].oe == 1'b0 && o_pad[5].oe == 1'b0)
        else $error("outputs driven while pin low");
    shutdown_stop_a: assert property (pdn_en && !pin_s |=> !o_osc_enable && !o_pll_cfg[1].en)
        else $error("shutdown left oscillator or PLL running");
    oe_only_a: assert property (!pdn_en && !pin_s |=> o_osc_enable)
        else $error("oscillator stopped in enable mode");
    div_zero_a: assert property (g_main[2].div == 7'h00 |=> !o_pad[2].oe)
        else $error("zero divider output driven");
    e_off_a: assert property (ediv == `COG_EDIV_OFF |=> !o_pad[4].oe)
        else $error("output E driven while off");
    xbuf_gate_a: assert property (!misc[`COG_MISC_XBUF_BIT] |=> !o_pad[5].oe)
        else $error("reference buffer driven while disabled");
    pll1_off_a: assert property (!pll_run[0] && g_main[2].fs[2:1] == 2'h1 |=> !o_pad[2].oe)
        else $error("output kept on first PLL while off");
    suspend_out_a: assert property (susp_active && susp_out[0] |=> !o_pad[0].oe)
        else $error("suspended output still driven");
    ack_commit_a: assert property (mem_we |=> o_sda_oe && sl_state_reg == COG_SL_WR_ACK)
        else $error("write not acknowledged");
    pll_ratio_a: assert property (!$past(i_reset) |-> o_pll_cfg[1].qt ==
        9'($past(cog_byte(bytes, `COG_IDX_PLL2))) + `COG_Q_OFFSET)
        else $error("PLL divisor total wrong");
endmodule : cog_top

// >>> test/cog_host.sv
/* Serial programming host for the clock output stage.
   Assumes an open-drain data line with pull-up; device pulls via i_sda_oe. */
`timescale 1ns/10ps
`include "cog_defs.svh"
module cog_host (
    input wire logic i_clk,
    input wire logic i_sda_oe,
    output logic o_scl,
    output logic o_sda
);
    int hp = 10;
    logic nack = 1'b0;
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic half();
        repeat (hp) @(negedge i_clk);
    endtask : half
    task automatic clk_bit(input logic b, output logic s);
        o_sda = b;
        half();
        o_scl = 1'b1;
        half();
        s = o_sda & ~i_sda_oe;
        o_scl = 1'b0;
    endtask : clk_bit
    task automatic send(input logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(v[i], s);
        end
        clk_bit(1'b1, s);
        if (s !== 1'b0) begin
            nack = 1'b1;
        end
    endtask : send
    // Byte order within a PLL setting is Q, P, control so enable lands last
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
        o_sda = 1'b0;
        half();
        o_scl = 1'b0;
        send({`COG_DEV_ADDR, 1'b0});
        send(ptr);
        foreach (d[i]) begin
            send(d[i]);
        end
        o_sda = 1'b0;
        half();
        o_scl = 1'b1;
        half();
        o_sda = 1'b1;
        half();
    endtask : wr
endmodule : cog_host

// >>> test/clock_output_routing_and_dividers_tb.sv
/* Bench for cog_top: programs it over the serial host, checks pads.
   Assumes ticks every 2 clk (reference) and 3 clk (PLLs). */
`timescale 1ns/10ps
module clock_output_routing_and_dividers_tb;
    import cog_pkg::*;
    logic clk, reset, scl, sda_h, sda_oe, pin_oe, sel_pin, last, osc;
    cog_src_t src;
    cog_pad_t [5:0] pad;
    cog_pll_cfg_t [2:0] pll;
    int fails = 0, n_tests = 0, msel = 0, cnt = 0, cyc = 0;
    logic [31:0] rs = 32'h9c29;
    logic [31:0] q[$];
    cog_host i_host (.i_clk(clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda_h));
    cog_top i_dut (.i_clk(clk), .i_reset(reset), .i_src(src), .i_scl(scl), .i_sda(sda_h & ~sda_oe),
        .o_sda_out(), .o_sda_oe(sda_oe), .i_shutdown_oe_pin(pin_oe), .i_freq_select_or_sleep_pin(sel_pin),
        .o_pad(pad), .o_pll_cfg(pll), .o_osc_enable(osc));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        cyc++;
        src.ref_half <= (cyc % 2 == 0);
        src.pll_half <= {3{cyc % 3 == 0}};
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    // Rise-to-rise period of the watched pad, sampled away from the launching edge
    always @(negedge clk) begin
        cnt = cnt + 1;
        if (pad[msel].out === 1'b1 && last === 1'b0) begin
            if (q.size() > 0) begin
                chk("period", q.pop_front(), cnt);
            end
            cnt = 0;
        end
        last = pad[msel].out;
    end
    // Let the divider settle before noting the expected period
    task automatic exp_per(int p);
        repeat (2 * p + 20) @(negedge clk);
        q.push_back(p);
        for (int i = 0; i < 3 * p + 10 && q.size() > 0; i++) begin
            @(negedge clk);
        end
        if (q.size() > 0) begin
            fails++;
            stop_test();
        end
    endtask : exp_per
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        stop_test();
    end
    initial begin
        logic [6:0] d;
        reset = 1'b1;
        src = '0;
        pin_oe = 1'b1;
        sel_pin = 1'b0;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        repeat (10) @(negedge clk);
        chk("duty_a", 2'h1, pad[0].duty);
        chk("drive_x", 2'h1, pad[5].drive);
        chk("oe_a", 1'h0, pad[0].oe);
        chk("oe_x", 1'h1, pad[5].oe);
        pin_oe = 1'b0;
        repeat (8) @(negedge clk);
        chk("oe_x_pin", 1'h0, pad[5].oe);
        pin_oe = 1'b1;
        i_host.hp = 14;
        i_host.wr(8'h49, '{8'h05, 8'h10, 8'h44});
        i_host.hp = 10;
        chk("pt", 12'd39, pll[0].pt);
        chk("qt", 9'd7, pll[0].qt);
        chk("en", 1'h1, pll[0].en);
        for (int i = 0; i < 4; i++) begin
            rs = xs(rs);
            d = (i == 0) ? 7'h7f : {3'h0, rs[3:0]} + 7'h1;
            i_host.wr(8'h08, '{{1'b0, d}});
            exp_per(4 * d);
        end
        i_host.wr(8'h09, '{8'h03});
        i_host.wr(8'h4b, '{8'hc4});
        exp_per(12);
        msel = 4;
        for (int c = 1; c < 4; c++) begin
            i_host.wr(8'h0f, '{8'h54 | c[7:0]});
            exp_per(c == 1 ? 24 : c == 2 ? 12 : 18);
        end
        i_host.wr(8'h4b, '{8'h84});
        repeat (6) @(negedge clk);
        chk("oe_e_pll", 1'h0, pad[4].oe);
        pin_oe = 1'b0;
        i_host.wr(8'h0f, '{8'h50});
        pin_oe = 1'b1;
        repeat (8) @(negedge clk);
        chk("oe_x_off", 1'h0, pad[5].oe);
        chk("ack", 1'h0, i_host.nack);
        // Suspend first PLL together with output E, which derives from it
        i_host.wr(8'h18, '{8'h10, 8'h09});
        repeat (8) @(negedge clk);
        chk("oe_e_susp", 1'h0, pad[4].oe);
        i_host.wr(8'h0f, '{8'h58});
        pin_oe = 1'b0;
        repeat (8) @(negedge clk);
        chk("osc_off", 1'h0, osc);
        pin_oe = 1'b1;
        // Allow relock time before relying on outputs again
        repeat (40) @(negedge clk);
        chk("osc_on", 1'h1, osc);
        stop_test();
    end
endmodule : clock_output_routing_and_dividers_tb
